// ===== hdl/lmmd_decoder.sv
// Purpose: Low address space decoder with two-way memory map
// Assumes: Strap pins valid while reset is held
// Notes:   Decode outputs registered one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module lmmd_decoder
  import lmmd_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // Boot strap pins
  input  wire logic [LMMD_STRAP_W-1:0] expansion_data_strap_pins,
  // Access request
  input  wire logic                    acc_valid,
  input  wire logic                    acc_write,
  input  wire logic [31:0]             acc_addr,
  // Register port
  input  wire logic [31:0]             reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [31:0]                  reg_rdata,
  // Decode results
  output logic                         chip_select_region_zero,
  output logic                         chip_select_region_one,
  output logic                         chip_select_region_two,
  output logic                         chip_select_region_three,
  output logic                         prog_ram_sel,
  output logic                         acc_write_en,
  output logic                         acc_reserved,
  output logic [31:0]                  region_ctl,
  output logic                         map_mode
);
  localparam int NREG = 6;

  logic               map_q;
  logic               map_d;
  logic               in_reset_q;
  logic [31:0]        gbl_q;
  logic [31:0]        gbl_d;
  logic [NREG-1:0]    wr_sel;
  logic [NREG-1:0]    rd_sel;
  logic [NREG*32-1:0] regs_flat;
  logic               gbl_wsel;
  logic               gbl_rsel;
  logic [7:0]         hit;
  lmmd_target_e       tgt;
  logic [31:0]        ctl_sel;
  logic               cs0_q;
  logic               cs1_q;
  logic               cs2_q;
  logic               cs3_q;
  logic               pram_q;
  logic               we_q;
  logic               rsv_q;
  logic [31:0]        ctl_q;
  logic [31:0]        rgn0_word;
  logic [31:0]        rgn1_word;
  logic [31:0]        rgn2_word;
  logic [31:0]        rgn3_word;

  // Range comparators, one per table row
  lmmd_range_match #(.LO(LMMD_R0_LO), .HI(LMMD_R0_HI)) u_r0 (.addr(acc_addr), .hit(hit[0]));
  lmmd_range_match #(.LO(LMMD_R1_LO), .HI(LMMD_R1_HI)) u_r1 (.addr(acc_addr), .hit(hit[1]));
  lmmd_range_match #(.LO(LMMD_R2_LO), .HI(LMMD_R2_HI)) u_r2 (.addr(acc_addr), .hit(hit[2]));
  lmmd_range_match #(.LO(LMMD_R3_LO), .HI(LMMD_R3_HI)) u_r3 (.addr(acc_addr), .hit(hit[3]));
  lmmd_range_match #(.LO(LMMD_R4_LO), .HI(LMMD_R4_HI)) u_r4 (.addr(acc_addr), .hit(hit[4]));
  lmmd_range_match #(.LO(LMMD_R5_LO), .HI(LMMD_R5_HI)) u_r5 (.addr(acc_addr), .hit(hit[5]));
  lmmd_range_match #(.LO(LMMD_R6_LO), .HI(LMMD_R6_HI)) u_r6 (.addr(acc_addr), .hit(hit[6]));
  lmmd_range_match #(.LO(LMMD_R7_LO), .HI(LMMD_R7_HI)) u_r7 (.addr(acc_addr), .hit(hit[7]));

  // Register address decode
  assign gbl_wsel  = reg_wr && (reg_addr == LMMD_GLOBAL_CTL_ADDR);
  assign gbl_rsel  = reg_addr == LMMD_GLOBAL_CTL_ADDR;
  assign wr_sel[0] = reg_addr == LMMD_RGN1_CTL_ADDR;
  assign wr_sel[1] = reg_addr == LMMD_RGN0_CTL_ADDR;
  assign wr_sel[2] = reg_addr == LMMD_RGN2_CTL_ADDR;
  assign wr_sel[3] = reg_addr == LMMD_RGN3_CTL_ADDR;
  assign wr_sel[4] = reg_addr == LMMD_SDRAM_CTL_ADDR;
  assign wr_sel[5] = reg_addr == LMMD_SDRAM_REF_ADDR;
  assign rd_sel    = wr_sel;

  lmmd_regfile #(.NREG(NREG)) u_regs (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .wr_sel    (wr_sel),
    .rd_sel    (rd_sel),
    .wr_stb    (reg_wr),
    .rd_stb    (reg_rd),
    .wr_data   (reg_wdata),
    .extra_rd  (gbl_q),
    .extra_sel (gbl_rsel),
    .regs_flat (regs_flat),
    .rd_data   (reg_rdata)
  );

  assign rgn1_word = regs_flat[0*32 +: 32];
  assign rgn0_word = regs_flat[1*32 +: 32];
  assign rgn2_word = regs_flat[2*32 +: 32];
  assign rgn3_word = regs_flat[3*32 +: 32];

  // strap capture during reset
  // Map follows the strap while reset is held, sampled by the clock
  always_comb begin
    map_d = map_q;
    if (!rst_n) begin
      map_d = expansion_data_strap_pins[LMMD_STRAP_MAP_BIT];
    end else if (gbl_wsel) begin
      map_d = reg_wdata[LMMD_MAP_BIT];
    end
  end

  // Global control word with live map bit
  always_comb begin
    gbl_d = gbl_q;
    if (gbl_wsel) begin
      gbl_d = reg_wdata;
    end
    gbl_d[LMMD_MAP_BIT] = map_d;
  end

  always_ff @(posedge sys_clk) begin
    map_q <= map_d;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gbl_q      <= LMMD_GLOBAL_CTL_RST;
      in_reset_q <= 1'b1;
    end else begin
      gbl_q      <= gbl_d;
      in_reset_q <= 1'b0;
    end
  end

  // Target selection by range and map
  always_comb begin
    tgt = LMMD_TGT_NONE;
    if (hit[0]) begin
      tgt = map_q ? LMMD_TGT_PRAM : LMMD_TGT_RGN0;
    end else if (hit[1]) begin
      tgt = map_q ? LMMD_TGT_NONE : LMMD_TGT_RGN0;
    end else if (hit[2]) begin
      tgt = LMMD_TGT_RGN0;
    end else if (hit[3]) begin
      tgt = map_q ? LMMD_TGT_RGN0 : LMMD_TGT_RGN1;
    end else if (hit[4]) begin
      tgt = map_q ? LMMD_TGT_RGN1 : LMMD_TGT_PRAM;
    end else if (hit[5]) begin
      tgt = map_q ? LMMD_TGT_RGN1 : LMMD_TGT_NONE;
    end else if (hit[6]) begin
      tgt = LMMD_TGT_RGN2;
    end else if (hit[7]) begin
      tgt = LMMD_TGT_RGN3;
    end
  end

  always_comb begin
    unique case (tgt)
      LMMD_TGT_RGN0: ctl_sel = rgn0_word;
      LMMD_TGT_RGN1: ctl_sel = rgn1_word;
      LMMD_TGT_RGN2: ctl_sel = rgn2_word;
      LMMD_TGT_RGN3: ctl_sel = rgn3_word;
      default:       ctl_sel = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cs0_q  <= 1'b0;
      cs1_q  <= 1'b0;
      cs2_q  <= 1'b0;
      cs3_q  <= 1'b0;
      pram_q <= 1'b0;
      we_q   <= 1'b0;
      rsv_q  <= 1'b0;
      ctl_q  <= 32'h0000_0000;
    end else begin
      cs0_q  <= acc_valid && (tgt == LMMD_TGT_RGN0);
      cs1_q  <= acc_valid && (tgt == LMMD_TGT_RGN1);
      cs2_q  <= acc_valid && (tgt == LMMD_TGT_RGN2);
      cs3_q  <= acc_valid && (tgt == LMMD_TGT_RGN3);
      pram_q <= acc_valid && (tgt == LMMD_TGT_PRAM);
      we_q   <= acc_valid && acc_write && (tgt != LMMD_TGT_NONE);
      rsv_q  <= acc_valid && (tgt == LMMD_TGT_NONE);
      ctl_q  <= acc_valid ? ctl_sel : 32'h0000_0000;
    end
  end

  // Outputs
  assign chip_select_region_zero  = cs0_q;
  assign chip_select_region_one   = cs1_q;
  assign chip_select_region_two   = cs2_q;
  assign chip_select_region_three = cs3_q;
  assign prog_ram_sel             = pram_q;
  assign acc_write_en             = we_q;
  assign acc_reserved             = rsv_q;
  assign region_ctl               = ctl_q;
  assign map_mode                 = map_q && !in_reset_q;
endmodule
`default_nettype wire

// ===== hdl/lmmd_pkg.sv
// Purpose: Shared constants for the low memory map decoder
// Assumes: 32-bit byte addresses, 32-bit register words
// Notes:   Offsets are byte addresses of the register window
package lmmd_pkg;

  // Register byte addresses
  localparam logic [31:0] LMMD_GLOBAL_CTL_ADDR = 32'h0180_0000;
  localparam logic [31:0] LMMD_RGN1_CTL_ADDR   = 32'h0180_0004;
  localparam logic [31:0] LMMD_RGN0_CTL_ADDR   = 32'h0180_0008;
  localparam logic [31:0] LMMD_RGN2_CTL_ADDR   = 32'h0180_0010;
  localparam logic [31:0] LMMD_RGN3_CTL_ADDR   = 32'h0180_0014;
  localparam logic [31:0] LMMD_SDRAM_CTL_ADDR  = 32'h0180_0018;
  localparam logic [31:0] LMMD_SDRAM_REF_ADDR  = 32'h0180_001c;

  // Global control fields
  localparam int          LMMD_MAP_BIT      = 0;
  localparam int          LMMD_STRAP_W      = 5;
  localparam int          LMMD_STRAP_MAP_BIT = 2;

  // Register reset values
  localparam logic [31:0] LMMD_GLOBAL_CTL_RST = 32'h0000_0000;
  localparam logic [31:0] LMMD_RGN_CTL_RST    = 32'h0000_0000;
  localparam logic [31:0] LMMD_SD_RST       = 32'h0000_0000;

  // Decode ranges, inclusive bounds
  localparam logic [31:0] LMMD_R0_LO = 32'h0000_0000;
  localparam logic [31:0] LMMD_R0_HI = 32'h0005_ffff;
  localparam logic [31:0] LMMD_R1_LO = 32'h0006_0000;
  localparam logic [31:0] LMMD_R1_HI = 32'h003f_ffff;
  localparam logic [31:0] LMMD_R2_LO = 32'h0040_0000;
  localparam logic [31:0] LMMD_R2_HI = 32'h00ff_ffff;
  localparam logic [31:0] LMMD_R3_LO = 32'h0100_0000;
  localparam logic [31:0] LMMD_R3_HI = 32'h013f_ffff;
  localparam logic [31:0] LMMD_R4_LO = 32'h0140_0000;
  localparam logic [31:0] LMMD_R4_HI = 32'h0145_ffff;
  localparam logic [31:0] LMMD_R5_LO = 32'h0146_0000;
  localparam logic [31:0] LMMD_R5_HI = 32'h017f_ffff;
  localparam logic [31:0] LMMD_R6_LO = 32'h0200_0000;
  localparam logic [31:0] LMMD_R6_HI = 32'h02ff_ffff;
  localparam logic [31:0] LMMD_R7_LO = 32'h0300_0000;
  localparam logic [31:0] LMMD_R7_HI = 32'h03ff_ffff;

  // Target encodings
  typedef enum logic [2:0] {
    LMMD_TGT_NONE,
    LMMD_TGT_RGN0,
    LMMD_TGT_RGN1,
    LMMD_TGT_RGN2,
    LMMD_TGT_RGN3,
    LMMD_TGT_PRAM
  } lmmd_target_e;

endpackage

// ===== hdl/lmmd_range_match.sv
// Purpose: Inclusive address range comparator
// Assumes: Bounds are constants
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module lmmd_range_match #(
  parameter logic [31:0] LO = 32'h0000_0000,
  parameter logic [31:0] HI = 32'h0000_0000
) (
  input  wire logic [31:0] addr,
  output logic             hit
);
  // Compare against both bounds
  assign hit = (addr >= LO) && (addr <= HI);
endmodule
`default_nettype wire

// ===== hdl/lmmd_regfile.sv
// Purpose: Register words of the external memory interface control
// Assumes: Single-cycle strobes from the register port
// Notes:   Read data registered, one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module lmmd_regfile
  import lmmd_pkg::*;
#(
  parameter int NREG = 6
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic [NREG-1:0]    wr_sel,
  input  wire logic [NREG-1:0]    rd_sel,
  input  wire logic               wr_stb,
  input  wire logic               rd_stb,
  input  wire logic [31:0]        wr_data,
  input  wire logic [31:0]        extra_rd,
  input  wire logic               extra_sel,
  output logic [NREG*32-1:0]      regs_flat,
  output logic [31:0]             rd_data
);
  logic [31:0] rd_d;

  // One word per register
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      logic [31:0] reg_q;
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          reg_q <= (g == NREG-1) ? LMMD_SD_RST : LMMD_RGN_CTL_RST;
        end else if (wr_stb && wr_sel[g]) begin
          reg_q <= wr_data;
        end
      end
      assign regs_flat[g*32 +: 32] = reg_q;
    end
  endgenerate

  // Read mux, unmapped reads zero
  always_comb begin
    rd_d = extra_sel ? extra_rd : 32'h0000_0000;
    for (int i = 0; i < NREG; i++) begin
      if (rd_sel[i]) begin
        rd_d = regs_flat[i*32 +: 32];
      end
    end
  end

  // Registered read data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_stb) begin
      rd_data <= rd_d;
    end else begin
      rd_data <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/lmmd_far_model.sv
// Purpose: Far side of the decoder: memory controller, program RAM, peripherals
// Assumes: Selects are one-hot one cycle after each access, or all low after a reserved access
// Notes:   Reports which target the far side sees as a code
`timescale 1ns/1ps
`default_nettype none
module lmmd_far_model
  import lmmd_pkg::*;
(
  input  wire logic       chip_select_region_zero,
  input  wire logic       chip_select_region_one,
  input  wire logic       chip_select_region_two,
  input  wire logic       chip_select_region_three,
  input  wire logic       prog_ram_sel,
  output logic [2:0]      hit_code
);
  // Target that answers the current cycle
  assign hit_code = chip_select_region_zero ? LMMD_TGT_RGN0 : chip_select_region_one ? LMMD_TGT_RGN1 :
                    chip_select_region_two ? LMMD_TGT_RGN2 : chip_select_region_three ? LMMD_TGT_RGN3 :
                    prog_ram_sel ? LMMD_TGT_PRAM : LMMD_TGT_NONE;
endmodule
`default_nettype wire

// ===== testbench/lmmd_decoder_sva.sv
// Purpose: Port checker for the low memory map decoder
// Assumes: Decode results one cycle after the access
// Notes:   Attached by bind below
`timescale 1ns/1ps
`default_nettype none
module lmmd_decoder_sva
  import lmmd_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    acc_valid,
  input  wire logic [31:0]             acc_addr,
  input  wire logic                    reg_wr,
  input  wire logic                    chip_select_region_zero,
  input  wire logic                    chip_select_region_one,
  input  wire logic                    chip_select_region_two,
  input  wire logic                    chip_select_region_three,
  input  wire logic                    prog_ram_sel,
  input  wire logic                    acc_write_en,
  input  wire logic                    acc_reserved,
  input  wire logic                    map_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Range hits of the current access
  wire logic in0 = acc_valid && acc_addr <= LMMD_R0_HI;
  wire logic in1 = acc_valid && acc_addr >= LMMD_R1_LO && acc_addr <= LMMD_R1_HI;
  wire logic in2 = acc_valid && acc_addr >= LMMD_R2_LO && acc_addr <= LMMD_R2_HI;
  wire logic in3 = acc_valid && acc_addr >= LMMD_R3_LO && acc_addr <= LMMD_R3_HI;
  wire logic in4 = acc_valid && acc_addr >= LMMD_R4_LO && acc_addr <= LMMD_R4_HI;
  wire logic in5 = acc_valid && acc_addr >= LMMD_R5_LO && acc_addr <= LMMD_R5_HI;
  wire logic in6 = acc_valid && acc_addr >= LMMD_R6_LO && acc_addr <= LMMD_R6_HI;
  wire logic in7 = acc_valid && acc_addr >= LMMD_R7_LO && acc_addr <= LMMD_R7_HI;
  wire logic any_sel = chip_select_region_zero | chip_select_region_one | chip_select_region_two |
                       chip_select_region_three | prog_ram_sel;
  // Decode of each range in each map, except range 1 in map zero
  a_low_map_zero: assert property (in0 && !map_mode |=> chip_select_region_zero && !prog_ram_sel)
    else $error("low range not on region zero");
  a_low_map_one: assert property (in0 && map_mode |=> prog_ram_sel && !chip_select_region_zero)
    else $error("low range not on program RAM");
  a_gap_map_one: assert property (in1 && map_mode |=> acc_reserved && !any_sel)
    else $error("gap range selected a target");
  a_mid_region_zero: assert property (in2 |=> chip_select_region_zero)
    else $error("middle range not on region zero");
  a_swap_one_zero: assert property (in3 |=> $past(map_mode) ? chip_select_region_zero : chip_select_region_one)
    else $error("region one window wrong");
  a_ram_swap: assert property (in4 |=> ($past(map_mode) ? chip_select_region_one : prog_ram_sel))
    else $error("program RAM window wrong");
  a_upper_gap: assert property (in5 |=> ($past(map_mode) ? chip_select_region_one : acc_reserved && !any_sel))
    else $error("upper gap window wrong");
  a_region_two_hit: assert property (in6 |=> chip_select_region_two)
    else $error("region two missed");
  a_region_three_hit: assert property (in7 |=> chip_select_region_three)
    else $error("region three missed");
  a_reserved_quiet: assert property (acc_reserved |-> !any_sel && !acc_write_en)
    else $error("reserved access drove a target");
  a_map_holds: assert property (rst_n && $past(rst_n) && $past(rst_n, 2) && !reg_wr |=> $stable(map_mode))
    else $error("map changed without a write");
endmodule
bind lmmd_decoder lmmd_decoder_sva lmmd_decoder_sva_inst (.*);
`default_nettype wire

// ===== testbench/testbench.sv
// Purpose: Self-checking bench of the low memory map decoder
// Assumes: Strap bit 2 picks the map, registers reset to 0
// Notes:   Row nibbles follow the package target order
`timescale 1ns/1ps
`default_nettype none
module testbench
  import lmmd_pkg::*;
;
  logic        sys_clk, rst_n, acc_valid, acc_write, reg_wr, reg_rd, map_mode;
  logic        chip_select_region_zero, chip_select_region_one, chip_select_region_two;
  logic        chip_select_region_three, prog_ram_sel, acc_write_en, acc_reserved;
  logic [4:0]  expansion_data_strap_pins;
  logic [31:0] acc_addr, reg_addr, reg_wdata, reg_rdata, region_ctl;
  logic [2:0]  hit_code;
  int          err_total, checks, cyc;
  // Address, map zero target, map one target
  logic [39:0] rows [18] = '{40'h00000000_15, 40'h0005ffff_15, 40'h00060000_10, 40'h003fffff_10,
    40'h00400000_11, 40'h00ffffff_11, 40'h01000000_21, 40'h013fffff_21, 40'h01400000_52,
    40'h0145ffff_52, 40'h01460000_02, 40'h017fffff_02, 40'h01800000_00, 40'h02000000_33,
    40'h02ffffff_33, 40'h03000000_44, 40'h03ffffff_44, 40'h04000000_00};
  lmmd_decoder lmmd_decoder_inst (.*);
  lmmd_far_model lmmd_far_model_inst (.*);
  // Clock and hang guard
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      finish_test;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task do_reset(input logic [4:0] strap);
    rst_n <= 0;
    expansion_data_strap_pins <= strap;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1;
  endtask
  task reg_write(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task reg_read(input logic [31:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, exp, "read data");
  endtask
  task acc_chk(input logic [31:0] a, input logic [2:0] code, input logic [31:0] ctl);
    @(posedge sys_clk);
    acc_valid <= 1;
    acc_addr <= a;
    @(posedge sys_clk);
    acc_valid <= 0;
    #1 chk(hit_code, code, "target");
    chk(region_ctl, ctl, "control word");
  endtask
  task t_map(input logic m);
    #1 chk(map_mode, m, "strap map");
    reg_read(LMMD_GLOBAL_CTL_ADDR, {31'h0, m});
    reg_read(LMMD_RGN2_CTL_ADDR, 32'h0);
    $display("map strap test done");
  endtask
  task t_decode(input logic m);
    logic [2:0] e;
    for (int i = 0; i <= 18; i++) begin
      @(posedge sys_clk);
      acc_valid <= i < 18;
      acc_addr <= rows[i % 18][39:8];
      acc_write <= i[0];
      if (i > 0) begin
        e = m ? rows[i-1][2:0] : rows[i-1][6:4];
        #1 chk(hit_code, e, "decode target");
        chk(acc_reserved, e == 0, "reserved flag");
        chk(acc_write_en, e != 0 && !i[0], "write enable");
      end
    end
    $display("decode table test done");
  endtask
  task t_ctl;
    reg_write(LMMD_RGN0_CTL_ADDR, 32'h0000_00c0);
    reg_write(LMMD_RGN1_CTL_ADDR, 32'h0000_00c1);
    reg_write(LMMD_RGN2_CTL_ADDR, 32'h0000_00c2);
    reg_write(LMMD_RGN3_CTL_ADDR, 32'h0000_00c3);
    reg_write(32'h0180_000c, 32'hffff_ffff);
    reg_write(LMMD_SDRAM_REF_ADDR, 32'h0000_05dc);
    reg_read(32'h0180_000c, 32'h0);
    reg_read(LMMD_SDRAM_REF_ADDR, 32'h0000_05dc);
    reg_read(LMMD_SDRAM_CTL_ADDR, 32'h0);
    reg_read(LMMD_RGN1_CTL_ADDR, 32'h0000_00c1);
    acc_chk(32'h0040_0000, LMMD_TGT_RGN0, 32'h0000_00c0);
    acc_chk(32'h0100_0000, LMMD_TGT_RGN1, 32'h0000_00c1);
    acc_chk(32'h0200_0000, LMMD_TGT_RGN2, 32'h0000_00c2);
    acc_chk(32'h0300_0000, LMMD_TGT_RGN3, 32'h0000_00c3);
    reg_write(LMMD_GLOBAL_CTL_ADDR, 32'h1);
    acc_chk(32'h0100_0000, LMMD_TGT_RGN0, 32'h0000_00c0);
    acc_chk(32'h0140_0000, LMMD_TGT_RGN1, 32'h0000_00c1);
    chk(map_mode, 1, "software map");
    $display("control word test done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence, second reset in mid-run
  initial begin
    {acc_valid, acc_write, reg_wr, reg_rd} = 4'h0;
    err_total = 0;
    checks = 0;
    cyc = 0;
    acc_addr = 32'h0000_0000;
    reg_addr = 32'h0000_0000;
    reg_wdata = 32'h0000_0000;
    rst_n = 0;
    expansion_data_strap_pins = 5'h1b;
    do_reset(5'h1b);
    @(posedge sys_clk);
    t_map(0);
    t_decode(0);
    t_ctl;
    @(posedge sys_clk);
    do_reset(5'h04);
    @(posedge sys_clk);
    t_map(1);
    t_decode(1);
    finish_test;
  end
endmodule
`default_nettype wire
